// ---- option_area_pkg.sv ----
// Purpose: Shared constants and types for the option-area unlock and erase block.
// Assumes: 32-bit AHB-Lite register bus, 512-byte pages, 128 KB main array.
// Notes: Offsets are byte addresses inside the block's 4 KB slot.
package option_area_pkg;

  // Register offsets
  localparam logic [11:0] OFF_MAIN_KEY = 12'h000;
  localparam logic [11:0] OFF_OPTION_KEY = 12'h004;
  localparam logic [11:0] OFF_STATUS = 12'h008;
  localparam logic [11:0] OFF_CONTROL = 12'h00C;
  localparam logic [11:0] OFF_TARGET_ADDR = 12'h010;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h040;
  // Read window onto the protection option page and the user data page
  localparam logic [1:0] WINDOW_SEL = 2'h1;

  // Unlock values
  localparam logic [31:0] FIRST_UNLOCK_VALUE = 32'h45670123;
  localparam logic [31:0] SECOND_UNLOCK_VALUE = 32'hCDEF89AB;

  // Array geometry
  localparam logic [31:0] MAIN_ARRAY_TOP = 32'h0001FFFF;
  localparam logic [31:0] STORE_BASE = 32'h00020400;
  localparam logic [31:0] STORE_TOP = 32'h000207FF;
  localparam logic [31:0] DATA_PAGE_BASE = 32'h00020600;
  localparam logic [31:0] DATA_PAGE_TOP = 32'h000207FF;
  localparam int unsigned DATA_PAGE_BYTES = 512;
  localparam logic [31:0] PROT_WORD_TOP = 32'h000205FC;
  localparam int unsigned PROT_WORD_STEP = 4;
  localparam int unsigned PROT_WORD_COUNT = 8;
  localparam int unsigned PROT_PAIR_COUNT = 128;
  localparam logic [15:0] PROT_DEFAULT = 16'hFFFF;

  // Control register fields
  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned CTRL_OPT_ERASE_BIT = 5;
  localparam int unsigned CTRL_LOCK_BIT = 7;
  localparam int unsigned CTRL_OWE_BIT = 9;

  // Status register fields, shared by the mask register
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_PROTECTION_ERROR_FLAG_BIT = 4;
  localparam int unsigned STAT_DONE_BIT = 5;
  localparam logic [31:0] IRQ_MASK_RESET = 32'h00000000;

  typedef enum logic [1:0] {KS_LOCKED, KS_HALF, KS_OPEN} key_stage_t;
  typedef enum logic [1:0] {ES_IDLE, ES_CHECK, ES_ERASE} erase_state_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [11:0] addr;
  } bus_req_t;

endpackage : option_area_pkg

// ---- prot_decode.sv ----
// Purpose: Turns the eight raw protection option words into per-pair flags.
// Assumes: Word k covers main-array pages 32k to 32k+31.
// Notes: Purely combinational; a set output bit means the pair is guarded.
`timescale 1ns/1ps
module prot_decode
  import option_area_pkg::*;
(
  // Raw option words, word 0 covers pages 0 to 31
  input wire logic [PROT_WORD_COUNT-1:0][31:0] i_words,
  // One bit per page pair, high when guarded
  output logic [PROT_PAIR_COUNT-1:0] o_pair_protected
);

  for (genvar k = 0; k < PROT_WORD_COUNT; k++) begin : g_word
    logic valid;
    logic [15:0] effective;
    assign valid = (i_words[k][31:16] == ~i_words[k][15:0]);
    assign effective = valid ? i_words[k][15:0] : PROT_DEFAULT;
    assign o_pair_protected[k*16 +: 16] = ~effective;
  end

endmodule : prot_decode

// ---- nvr_store.sv ----
// Purpose: Protection option page and user data page, with word program and page erase.
// Assumes: Two pages; page 0 at the option page base, page 1 is the user data page.
// Notes: Contents survive reset like flash; the initial fill models a blank part.
`timescale 1ns/1ps
module nvr_store
  import option_area_pkg::*;
#(
  parameter int unsigned WORDS_PER_PAGE = 128
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_srst,
  // Read port
  input wire logic [$clog2(WORDS_PER_PAGE):0] i_rd_index,
  output logic [31:0] o_rd_data,
  // Word program, can only clear bits
  input wire logic i_prog_en,
  input wire logic [$clog2(WORDS_PER_PAGE):0] i_prog_index,
  input wire logic [31:0] i_prog_data,
  // Page erase
  input wire logic i_erase_go,
  input wire logic i_erase_page,
  output logic o_erase_busy,
  output logic o_erase_done,
  // Protection words, word 0 first
  output logic [PROT_WORD_COUNT-1:0][31:0] o_prot_words
);

  localparam int unsigned PW = $clog2(WORDS_PER_PAGE);

  if (WORDS_PER_PAGE * 4 != DATA_PAGE_BYTES || WORDS_PER_PAGE < PROT_WORD_COUNT) begin : g_bad_size
    $error("nvr_store: page size must match the user data page");
  end

  // Blank part at power-up; no reset, like the flash it stands for
  logic [31:0] mem_q [2*WORDS_PER_PAGE] = '{default: 32'hFFFFFFFF};
  logic [PW-1:0] idx_q;
  logic page_q;
  logic busy_q;
  logic done_q;

  assign o_rd_data = mem_q[i_rd_index];
  assign o_erase_busy = busy_q;
  assign o_erase_done = done_q;

  for (genvar k = 0; k < PROT_WORD_COUNT; k++) begin : g_prot
    assign o_prot_words[k] = mem_q[WORDS_PER_PAGE - 1 - k];
  end

  always_ff @(posedge i_clk_sys) begin
    if (busy_q) begin
      mem_q[{page_q, idx_q}] <= 32'hFFFFFFFF;
    end else if (i_prog_en) begin
      mem_q[i_prog_index] <= mem_q[i_prog_index] & i_prog_data;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      idx_q <= '0;
      page_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (!busy_q && i_erase_go) begin
        busy_q <= 1'b1;
        idx_q <= '0;
        page_q <= i_erase_page;
      end else if (busy_q) begin
        idx_q <= idx_q + 1'b1;
        if (idx_q == PW'(WORDS_PER_PAGE - 1)) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end

  property p_erased_word_ones;
    @(posedge i_clk_sys) disable iff (i_srst)
    busy_q |=> (mem_q[{$past(page_q), $past(idx_q)}] == 32'hFFFFFFFF);
  endproperty
  a_erased_word_ones: assert property (p_erased_word_ones) else $error("erased word not all ones");

endmodule : nvr_store

// ---- option_area_unlock_erase.sv ----
// Purpose: Key unlock, protection decode and page erase for the option and user data areas.
// Assumes: Zero-wait AHB-Lite slave; master issues single word transfers.
// Notes: A read that directly follows a write in the pipeline sees the value from before that write.
//
// The AHB-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
module option_area_unlock_erase
  import option_area_pkg::*;
#(
  parameter int unsigned WORDS_PER_PAGE = 128
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_srst,
  // AHB-Lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  // Interrupt
  output logic o_irq,
  // Guarded page pairs for the main array controller
  output logic [PROT_PAIR_COUNT-1:0] o_pair_protected
);

  if (WORDS_PER_PAGE * 4 != DATA_PAGE_BYTES) begin : g_bad_page
    $error("option_area_unlock_erase: page size must be 512 bytes");
  end

  localparam int unsigned PW = $clog2(WORDS_PER_PAGE);

  bus_req_t req_q;
  logic addr_phase;
  logic wr_en;
  logic [31:0] rd_d;
  logic [31:0] hrdata_q;
  logic stat_rd;
  key_stage_t key_stage_q;
  logic opt_half_q;
  logic owe_q;
  logic opt_erase_q;
  logic start_q;
  logic [31:0] target_q;
  logic [31:0] irq_mask_q;
  logic protection_error_flag_q;
  logic done_q;
  erase_state_t state_q;
  logic busy;
  logic unlocked;
  logic wr_main_key;
  logic wr_option_key;
  logic wr_ctrl;
  logic wr_target;
  logic wr_mask;
  logic wr_window;
  logic start_go;
  logic relock;
  logic tgt_in_main;
  logic tgt_in_store;
  logic tgt_protected;
  logic protection_error_flag_set;
  logic done_set;
  logic erase_go;
  logic prot_loaded_q;
  logic [PROT_PAIR_COUNT-1:0] prot_q;
  logic [PROT_PAIR_COUNT-1:0] prot_live;
  logic [PROT_WORD_COUNT-1:0][31:0] prot_words;
  logic [31:0] store_rd_data;
  logic store_busy;
  logic store_done;

  // Bus front end
  assign addr_phase = i_hsel && i_hready && i_htrans[1];
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign o_hrdata = hrdata_q;
  assign wr_en = req_q.valid && req_q.write;
  assign stat_rd = addr_phase && !i_hwrite && (i_haddr[11:0] == OFF_STATUS);

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      req_q <= '0;
    end else begin
      req_q <= '{valid: addr_phase, write: i_hwrite, addr: i_haddr[11:0]};
    end
  end

  always_comb begin
    rd_d = 32'h00000000;
    if (i_haddr[11:10] == WINDOW_SEL) begin
      rd_d = store_rd_data;
    end else begin
      unique case (i_haddr[11:0])
        OFF_STATUS: begin
          rd_d[STAT_BUSY_BIT] = busy;
          rd_d[STAT_PROTECTION_ERROR_FLAG_BIT] = protection_error_flag_q;
          rd_d[STAT_DONE_BIT] = done_q;
        end
        OFF_CONTROL: begin
          rd_d[CTRL_START_BIT] = start_q;
          rd_d[CTRL_OPT_ERASE_BIT] = opt_erase_q;
          rd_d[CTRL_LOCK_BIT] = !unlocked;
          rd_d[CTRL_OWE_BIT] = owe_q;
        end
        OFF_TARGET_ADDR: rd_d = target_q;
        OFF_IRQ_MASK: rd_d = irq_mask_q;
        default: rd_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      hrdata_q <= 32'h00000000;
    end else if (addr_phase && !i_hwrite) begin
      hrdata_q <= rd_d;
    end
  end

  // Write decode, applied in the data phase
  assign unlocked = (key_stage_q == KS_OPEN);
  assign wr_main_key = wr_en && (req_q.addr == OFF_MAIN_KEY);
  assign wr_option_key = wr_en && (req_q.addr == OFF_OPTION_KEY);
  assign wr_ctrl = wr_en && (req_q.addr == OFF_CONTROL) && unlocked;
  assign wr_target = wr_en && (req_q.addr == OFF_TARGET_ADDR) && unlocked && !busy;
  assign wr_mask = wr_en && (req_q.addr == OFF_IRQ_MASK);
  assign relock = wr_ctrl && i_hwdata[CTRL_LOCK_BIT];
  assign wr_window = wr_en && (req_q.addr[11:10] == WINDOW_SEL) && owe_q && !busy;

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      key_stage_q <= KS_LOCKED;
    end else if (relock) begin
      key_stage_q <= KS_LOCKED;
    end else if (wr_main_key) begin
      unique case (key_stage_q)
        KS_LOCKED: key_stage_q <= (i_hwdata == FIRST_UNLOCK_VALUE) ? KS_HALF : KS_LOCKED;
        KS_HALF: key_stage_q <= (i_hwdata == SECOND_UNLOCK_VALUE) ? KS_OPEN : KS_LOCKED;
        KS_OPEN: key_stage_q <= KS_OPEN;
        default: key_stage_q <= KS_LOCKED;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      opt_half_q <= 1'b0;
      owe_q <= 1'b0;
    end else if (relock) begin
      opt_half_q <= 1'b0;
      owe_q <= 1'b0;
    end else if (wr_option_key && unlocked) begin
      opt_half_q <= !opt_half_q && (i_hwdata == FIRST_UNLOCK_VALUE);
      if (opt_half_q && (i_hwdata == SECOND_UNLOCK_VALUE)) begin
        owe_q <= 1'b1;
      end
    end else if (wr_ctrl && !i_hwdata[CTRL_OWE_BIT]) begin
      owe_q <= 1'b0;
    end
  end

  assign start_go = wr_ctrl && !relock && i_hwdata[CTRL_START_BIT] && i_hwdata[CTRL_OPT_ERASE_BIT]
                    && i_hwdata[CTRL_OWE_BIT] && owe_q && (state_q == ES_IDLE);

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      opt_erase_q <= 1'b0;
      start_q <= 1'b0;
    end else begin
      start_q <= start_go;
      if (relock) begin
        opt_erase_q <= 1'b0;
      end else if (wr_ctrl) begin
        opt_erase_q <= i_hwdata[CTRL_OPT_ERASE_BIT];
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      target_q <= 32'h00000000;
      irq_mask_q <= IRQ_MASK_RESET;
    end else begin
      if (wr_target) begin
        target_q <= i_hwdata;
      end
      if (wr_mask) begin
        irq_mask_q <= i_hwdata;
      end
    end
  end

  // Protection words are taken once after reset, so new words apply after the next reset
  prot_decode u_prot_decode (
    .i_words(prot_words),
    .o_pair_protected(prot_live)
  );

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      prot_loaded_q <= 1'b0;
      prot_q <= '0;
    end else if (!prot_loaded_q) begin
      prot_loaded_q <= 1'b1;
      prot_q <= prot_live;
    end
  end

  assign o_pair_protected = prot_q;

  // Target classification
  assign tgt_in_main = (target_q <= MAIN_ARRAY_TOP);
  assign tgt_in_store = (target_q >= STORE_BASE) && (target_q <= STORE_TOP);
  assign tgt_protected = prot_q[target_q[16:10]];

  // Erase sequencer
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      state_q <= ES_IDLE;
    end else begin
      unique case (state_q)
        ES_IDLE: state_q <= start_go ? ES_CHECK : ES_IDLE;
        ES_CHECK: state_q <= (tgt_in_store && !tgt_in_main) ? ES_ERASE : ES_IDLE;
        ES_ERASE: state_q <= store_done ? ES_IDLE : ES_ERASE;
        default: state_q <= ES_IDLE;
      endcase
    end
  end

  assign busy = (state_q != ES_IDLE);
  assign protection_error_flag_set = (state_q == ES_CHECK) && tgt_in_main && tgt_protected;
  assign erase_go = (state_q == ES_CHECK) && tgt_in_store;
  assign done_set = (state_q == ES_ERASE) && store_done;

  nvr_store #(
    .WORDS_PER_PAGE(WORDS_PER_PAGE)
  ) u_nvr_store (
    .i_clk_sys(i_clk_sys),
    .i_srst(i_srst),
    .i_rd_index(i_haddr[PW+2:2]),
    .o_rd_data(store_rd_data),
    .i_prog_en(wr_window),
    .i_prog_index(req_q.addr[PW+2:2]),
    .i_prog_data(i_hwdata),
    .i_erase_go(erase_go),
    .i_erase_page(target_q >= DATA_PAGE_BASE),
    .o_erase_busy(store_busy),
    .o_erase_done(store_done),
    .o_prot_words(prot_words)
  );

  // Sticky flags, a set in the clearing cycle wins
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      protection_error_flag_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      if (protection_error_flag_set) begin
        protection_error_flag_q <= 1'b1;
      end else if (stat_rd) begin
        protection_error_flag_q <= 1'b0;
      end
      if (done_set) begin
        done_q <= 1'b1;
      end else if (stat_rd) begin
        done_q <= 1'b0;
      end
    end
  end

  assign o_irq = (protection_error_flag_q && irq_mask_q[STAT_PROTECTION_ERROR_FLAG_BIT]) || (done_q && irq_mask_q[STAT_DONE_BIT]);

  property p_locked_after_reset;
    @(posedge i_clk_sys) disable iff (i_srst)
    $past(i_srst) |-> (!owe_q && key_stage_q == KS_LOCKED);
  endproperty
  a_locked_after_reset: assert property (p_locked_after_reset) else $error("not locked after reset");

  property p_owe_needs_second_key;
    @(posedge i_clk_sys) disable iff (i_srst)
    $rose(owe_q) |-> $past(wr_option_key && opt_half_q && i_hwdata == SECOND_UNLOCK_VALUE && unlocked);
  endproperty
  a_owe_needs_second_key: assert property (p_owe_needs_second_key) else $error("write-enable set without key");

  property p_start_ignored;
    @(posedge i_clk_sys) disable iff (i_srst)
    (wr_ctrl && i_hwdata[CTRL_START_BIT] && !owe_q && state_q == ES_IDLE) |=> (state_q == ES_IDLE && !start_q);
  endproperty
  a_start_ignored: assert property (p_start_ignored) else $error("start taken without write-enable");

  property p_start_self_clears;
    @(posedge i_clk_sys) disable iff (i_srst)
    start_q |=> !start_q;
  endproperty
  a_start_self_clears: assert property (p_start_self_clears) else $error("start bit stuck");

  property p_busy_during_erase;
    @(posedge i_clk_sys) disable iff (i_srst)
    erase_go |=> (store_busy && busy) [*8];
  endproperty
  a_busy_during_erase: assert property (p_busy_during_erase) else $error("busy low during erase");

  property p_done_after_erase;
    @(posedge i_clk_sys) disable iff (i_srst)
    (store_done && state_q == ES_ERASE) |=> (done_q && !busy);
  endproperty
  a_done_after_erase: assert property (p_done_after_erase) else $error("done flag missing");

  property p_protected_abort;
    @(posedge i_clk_sys) disable iff (i_srst)
    (state_q == ES_CHECK && tgt_in_main && tgt_protected) |=> (protection_error_flag_q && !store_busy && state_q == ES_IDLE);
  endproperty
  a_protected_abort: assert property (p_protected_abort) else $error("protected erase not aborted");

  property p_blank_unprotected;
    @(posedge i_clk_sys) disable iff (i_srst)
    (prot_words[0] == 32'hFFFFFFFF) |-> (prot_live[15:0] == 16'h0000);
  endproperty
  a_blank_unprotected: assert property (p_blank_unprotected) else $error("blank word protects");

  property p_bad_word_default;
    @(posedge i_clk_sys) disable iff (i_srst)
    (prot_words[2][31:16] != ~prot_words[2][15:0]) |-> (prot_live[47:32] == 16'h0000);
  endproperty
  a_bad_word_default: assert property (p_bad_word_default) else $error("invalid word not defaulted");

  property p_zero_bit_protects;
    @(posedge i_clk_sys) disable iff (i_srst)
    (prot_words[0] == 32'hFFFE0001) |-> (prot_live[15:0] == 16'hFFFE);
  endproperty
  a_zero_bit_protects: assert property (p_zero_bit_protects) else $error("pair mapping wrong");

  c_unlock: cover property (@(posedge i_clk_sys) disable iff (i_srst) $rose(owe_q));
  c_erase_done: cover property (@(posedge i_clk_sys) disable iff (i_srst) done_set);
  c_protection_error_flag: cover property (@(posedge i_clk_sys) disable iff (i_srst) protection_error_flag_set);

endmodule : option_area_unlock_erase

// ---- option_area_tb.sv ----
// Purpose: Self-checking bench for option_area_unlock_erase over its AHB-Lite slave port.
// Assumes: Blank store at start; the bus tasks wait for hready although the slave never stalls.
// Notes: Protection flags latch only after reset, so the bench resets again after writing words.
`timescale 1ns/1ps
module testbench
  import option_area_pkg::*;
;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic irq;
  logic [PROT_PAIR_COUNT-1:0] pairs;
  int fail_count = 0;
  int check_count = 0;

  always #5 clk_sys = ~clk_sys;

  option_area_unlock_erase #(.WORDS_PER_PAGE(128)) i_dut (
    .i_clk_sys(clk_sys),
    .i_srst(srst),
    .i_hsel(hsel),
    .i_haddr(haddr),
    .i_htrans(htrans),
    .i_hwrite(hwrite),
    .i_hsize(hsize),
    .i_hwdata(hwdata),
    .i_hready(hreadyout),
    .o_hreadyout(hreadyout),
    .o_hresp(hresp),
    .o_hrdata(hrdata),
    .o_irq(irq),
    .o_pair_protected(pairs)
  );

  task automatic end_sim;
    if (fail_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask : chk

  task automatic chk_pairs(input logic [PROT_PAIR_COUNT-1:0] exp);
    check_count++;
    if (pairs !== exp) begin
      fail_count++;
      $display("unexpected pairs: expected %h, seen %h", exp, pairs);
    end
  endtask : chk_pairs

  // One single transfer; read data is taken at the data-phase edge
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge clk_sys iff hreadyout === 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk_sys iff hreadyout === 1'b1);
    q = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask : rd

  task automatic do_reset;
    srst <= 1'b1;
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    // Flags load at the first edge after release
    repeat (3) @(posedge clk_sys);
  endtask : do_reset

  task automatic unlock;
    wr(OFF_MAIN_KEY, FIRST_UNLOCK_VALUE);
    wr(OFF_MAIN_KEY, SECOND_UNLOCK_VALUE);
    wr(OFF_OPTION_KEY, FIRST_UNLOCK_VALUE);
    wr(OFF_OPTION_KEY, SECOND_UNLOCK_VALUE);
  endtask : unlock

  task automatic do_erase(input logic [31:0] target);
    wr(OFF_CONTROL, 32'h220);
    wr(OFF_TARGET_ADDR, target);
    wr(OFF_CONTROL, 32'h221);
  endtask : do_erase

  // Bounded wait; the caller judges the level afterwards
  task automatic wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 400) begin
      @(posedge clk_sys);
      n++;
    end
  endtask : wait_irq

  task automatic t_reset_values;
    logic [31:0] q;
    rd(OFF_STATUS, q);
    chk("status", 32'h0, q); // idle
    rd(OFF_CONTROL, q);
    chk("control", 32'h80, q & 32'h2A1); // locked
    rd(12'h100, q);
    chk("unmapped", 32'h0, q);
    rd(12'h5FC, q);
    chk("word0", 32'hFFFFFFFF, q); // readable
    chk("irq", 32'h0, {31'h0, irq});
    chk_pairs('0); // blank default
  endtask : t_reset_values

  task automatic t_locked;
    logic [31:0] q;
    wr(12'h5FC, 32'h0);
    rd(12'h5FC, q);
    chk("locked write", 32'hFFFFFFFF, q); // blocked
    wr(OFF_CONTROL, 32'h221);
    rd(OFF_STATUS, q);
    chk("locked start", 32'h0, q); // ignored
    // Wrong middle value drops the sequence back to locked
    wr(OFF_MAIN_KEY, FIRST_UNLOCK_VALUE);
    wr(OFF_MAIN_KEY, 32'h0);
    wr(OFF_MAIN_KEY, SECOND_UNLOCK_VALUE);
    wr(OFF_OPTION_KEY, FIRST_UNLOCK_VALUE);
    wr(OFF_OPTION_KEY, SECOND_UNLOCK_VALUE);
    rd(OFF_CONTROL, q);
    chk("bad keys", 32'h80, q & 32'h2A1); // wrong key
  endtask : t_locked

  task automatic t_unlock;
    logic [31:0] q;
    wr(OFF_MAIN_KEY, FIRST_UNLOCK_VALUE);
    wr(OFF_MAIN_KEY, SECOND_UNLOCK_VALUE);
    // Control open but write-enable still low
    wr(OFF_CONTROL, 32'h221);
    rd(OFF_STATUS, q);
    chk("no enable start", 32'h0, q); // ignored
    wr(OFF_OPTION_KEY, FIRST_UNLOCK_VALUE);
    wr(OFF_OPTION_KEY, SECOND_UNLOCK_VALUE);
    rd(OFF_CONTROL, q);
    chk("unlocked", 32'h220, q & 32'h2A1); // enable set
  endtask : t_unlock

  task automatic t_protect;
    logic [31:0] q;
    wr(12'h5FC, 32'hFFFE0001);
    wr(12'h5F8, 32'hFFFF0000);
    wr(12'h5F4, 32'h00000000);
    wr(12'h5E0, 32'hFF7F0080);
    rd(12'h5FC, q);
    chk("word0 prog", 32'hFFFE0001, q); // first word
    do_reset();
    chk("pairs 0", 32'h0000FFFE, {16'h0, pairs[15:0]}); // zero guards
    chk("pairs 1", 32'h0000FFFF, {16'h0, pairs[31:16]}); // word mapping
    chk("pairs 2", 32'h0, {16'h0, pairs[47:32]}); // bad inverse
    chk("pairs 7", 32'h0000FF7F, {16'h0, pairs[127:112]}); // last word
    chk_pairs({16'hFF7F, 80'h0, 16'hFFFF, 16'hFFFE}); // others default
  endtask : t_protect

  task automatic t_erase_data;
    logic [31:0] q;
    unlock();
    wr(OFF_IRQ_MASK, 32'h20);
    wr(12'h600, 32'h12345678);
    wr(12'h7FC, 32'h0);
    rd(12'h600, q);
    chk("data prog", 32'h12345678, q); // data page
    do_erase(DATA_PAGE_BASE);
    rd(OFF_STATUS, q);
    chk("busy", 32'h1, q); // busy high
    wait_irq();
    chk("irq done", 32'h1, {31'h0, irq}); // done raised
    rd(OFF_STATUS, q);
    chk("done", 32'h20, q); // done flag
    chk("irq clear", 32'h0, {31'h0, irq});
    rd(12'h600, q);
    chk("erased", 32'hFFFFFFFF, q); // all ones
    rd(12'h7FC, q);
    chk("erased top", 32'hFFFFFFFF, q); // page top
    rd(OFF_CONTROL, q);
    chk("start", 32'h0, q & 32'h1); // self clear
  endtask : t_erase_data

  task automatic t_prot_error;
    logic [31:0] q;
    wr(OFF_IRQ_MASK, 32'h0);
    do_erase(32'h00000400);
    repeat (4) @(posedge clk_sys);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(OFF_IRQ_MASK, 32'h10);
    @(posedge clk_sys);
    chk("irq protection_error_flag", 32'h1, {31'h0, irq}); // error raised
    rd(OFF_STATUS, q);
    chk("protection_error_flag", 32'h10, q); // error flag
    do_erase(32'h0);
    repeat (4) @(posedge clk_sys);
    rd(OFF_STATUS, q);
    chk("open pair", 32'h0, q); // no flag
  endtask : t_prot_error

  task automatic t_relock;
    logic [31:0] q;
    wr(OFF_IRQ_MASK, 32'h20);
    do_erase(STORE_BASE);
    wait_irq();
    rd(OFF_STATUS, q);
    chk("opt done", 32'h20, q); // option page
    rd(12'h5F8, q);
    chk("opt erased", 32'hFFFFFFFF, q); // option page
    wr(OFF_CONTROL, 32'h80);
    rd(OFF_CONTROL, q);
    chk("relocked", 32'h80, q & 32'h2A1); // enable cleared
    wr(12'h604, 32'h0);
    rd(12'h604, q);
    chk("relocked write", 32'hFFFFFFFF, q); // writes blocked
    do_reset();
    chk_pairs('0); // erased default
  endtask : t_relock

  // Whole run is about five hundred cycles; this limit is about a hundred times that
  initial begin
    #500000;
    fail_count++;
    end_sim();
  end

  initial begin
    do_reset();
    t_reset_values();
    t_locked();
    t_unlock();
    t_protect();
    t_erase_data();
    t_prot_error();
    t_relock();
    end_sim();
  end
endmodule : testbench
